// ===== logic/hbe_pkg.sv
// Purpose: Shared constants for the half-bridge enable register bank and its host.
// Assumes: One 40 MHz core clock at both ends; serial frames are sent LSB first.
// Notes:   Frame is address byte then data byte, 16 bits in all.
package hbe_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int         FRAME_BITS   = 16;
    localparam int         BYTE_BITS    = 8;
    localparam int         OP_BIT       = 7;
    localparam int         PAT_MSB      = 6;
    localparam int         PAT_LSB      = 2;
    localparam int         TOKEN_BIT    = 1;
    localparam int         TAIL_BIT     = 0;
    localparam logic [4:0] PAT_GROUP_A  = 5'h00;
    localparam logic [4:0] PAT_GROUP_B  = 5'h10;
    localparam logic [4:0] PAT_CONFIG   = 5'h13;

    // ------------------------------------------------------------------
    // Device register reset values and bridge count
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_GROUP    = 8'h00;
    localparam logic [7:0] RST_CONFIG   = 8'h01;
    localparam int         BRIDGES      = 8;

    // ------------------------------------------------------------------
    // Serial clock timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 25;
    localparam int SCLK_HALF_NS   = 200;
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Host command port map
    // ------------------------------------------------------------------
    localparam logic [2:0] HOFS_TX_ADDR = 3'h0;
    localparam logic [2:0] HOFS_TX_DATA = 3'h1;
    localparam logic [2:0] HOFS_CTRL    = 3'h2;
    localparam logic [2:0] HOFS_STATUS  = 3'h3;
    localparam logic [2:0] HOFS_RX_DATA = 3'h4;
    localparam int         CTRL_START   = 0;
    localparam int         CTRL_WRITE   = 1;
    localparam int         STAT_BUSY    = 0;
    localparam logic [7:0] RST_HOST     = 8'h00;

    // Host frame sequencer states.
    typedef enum logic [2:0] {
        HBE_IDLE  = 3'b000,
        HBE_LEAD  = 3'b001,
        HBE_XFER  = 3'b010,
        HBE_TRAIL = 3'b011,
        HBE_GAP   = 3'b100
    } hbe_state_t;

endpackage : hbe_pkg

// ===== logic/hbe_spi_if.sv
// Purpose: Serial link between the register bank and its controlling host.
// Assumes: The returned data line is resolved here from its enable.
// Notes:   An undriven return line reads as zero, standing in for a pull-down.
`timescale 1ns/10ps
interface hbe_spi_if;
    logic sclk;
    logic csn;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_wire;

    // Resolve the return line; the device drives it only inside a frame.
    assign miso_wire = miso_oe ? miso : 1'b0;

    modport device (input sclk, input csn, input mosi, output miso, output miso_oe);
    modport host   (output sclk, output csn, output mosi, input miso_wire);
endinterface : hbe_spi_if

// ===== logic/hbe_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin inputs.
// Assumes: Inputs are levels slower than the core clock.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/10ps
module hbe_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_nrst,
    // Asynchronous input and synchronised output
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    genvar g;

    // ------------------------------------------------------------------
    // Per-bit flip-flop pair
    // ------------------------------------------------------------------
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            // The first stage feeds nothing but the second.
            always_ff @(posedge i_core_clk) begin
                if (!i_nrst) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= i_async[g];
                    sync_reg <= meta_reg;
                end
            end
            assign o_sync[g] = sync_reg;
        end
    endgenerate

endmodule : hbe_sync

// ===== logic/hbe_device.sv
// Purpose: Half-bridge enable register bank behind a 16-bit serial frame.
// Assumes: Serial pins are asynchronous and much slower than the core clock.
// Notes:   Mode 1 timing: sample on falling edge, shift out on rising edge.
`timescale 1ns/10ps
module hbe_device
    import hbe_pkg::*;
(
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_nrst,

    // Serial link
    hbe_spi_if.device         link,

    // Register contents
    output logic [7:0]        o_group_a,
    output logic [7:0]        o_group_b,

    // Switch drives
    output logic [BRIDGES-1:0] o_high_on,
    output logic [BRIDGES-1:0] o_low_on
);

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    logic [2:0] pins_s;
    logic       sclk_s;
    logic       csn_s;
    logic       mosi_s;

    logic       sclk_q_reg;
    logic       csn_q_reg;

    hbe_sync #(.W(3)) u_sync (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_async    ({link.mosi, ~link.csn, link.sclk}),
        .o_sync     (pins_s)
    );

    assign sclk_s = pins_s[0];
    assign csn_s  = ~pins_s[1]; // Held inverted so reset reads idle.
    assign mosi_s = pins_s[2];

    // Chip select idles high, so its history resets high to avoid a false frame end.
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            sclk_q_reg <= 1'b0;
            csn_q_reg  <= 1'b1;
        end else begin
            sclk_q_reg <= sclk_s;
            csn_q_reg  <= csn_s;
        end
    end

    // One-cycle edge and frame strobes.
    wire sclk_rise  = sclk_s & ~sclk_q_reg;
    wire sclk_fall  = ~sclk_s & sclk_q_reg;

    wire frame_on   = ~csn_s;
    wire frame_beg  = ~csn_s & csn_q_reg;
    wire frame_end  = csn_s & ~csn_q_reg;

    // ------------------------------------------------------------------
    // Frame receiver
    // ------------------------------------------------------------------
    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] shift_next;

    logic [4:0]            cnt_reg;
    logic [4:0]            cnt_next;

    logic [7:0]            addr_reg;
    logic [7:0]            addr_next;

    // Clocks past the sixteenth bit are ignored.
    wire take_bit  = frame_on & sclk_fall & (cnt_reg < 5'(FRAME_BITS));
    wire addr_last = take_bit & (cnt_reg == 5'(BYTE_BITS - 1));

    // Bits arrive LSB first, address byte first.
    assign shift_next = take_bit ? {mosi_s, shift_reg[FRAME_BITS-1:1]} : shift_reg;
    assign cnt_next   = frame_beg ? 5'h00 : (take_bit ? cnt_reg + 5'h01 : cnt_reg);
    assign addr_next  = frame_beg ? 8'h00
                      : (addr_last ? {mosi_s, shift_reg[FRAME_BITS-1:9]} : addr_reg);

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            shift_reg <= 16'h0000;
            cnt_reg   <= 5'h00;
            addr_reg  <= 8'h00;
        end else begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            addr_reg  <= addr_next;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // The token bit is not decoded.
    wire [4:0] pat       = addr_reg[PAT_MSB:PAT_LSB];
    wire       tail_ok   = addr_reg[TAIL_BIT];
    wire       sel_a     = tail_ok & (pat == PAT_GROUP_A);
    wire       sel_b     = tail_ok & (pat == PAT_GROUP_B);
    wire       sel_cfg   = tail_ok & (pat == PAT_CONFIG);

    wire       is_write  = addr_reg[OP_BIT];

    // A write takes effect only when at least sixteen bits were clocked in; clocks past the sixteenth do not block it.
    wire       commit    = frame_end & (cnt_reg == 5'(FRAME_BITS)) & is_write;

    wire [7:0] rx_data   = shift_reg[FRAME_BITS-1:BYTE_BITS];

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    logic [7:0] group_a_reg;
    logic [7:0] group_b_reg;
    logic [7:0] config_reg;

    // Only a committed write frame changes a control register.
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            group_a_reg <= RST_GROUP;
            group_b_reg <= RST_GROUP;
            config_reg  <= RST_CONFIG;
        end else begin
            if (commit && sel_a) begin
                group_a_reg <= rx_data;
            end

            if (commit && sel_b) begin
                group_b_reg <= rx_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read return path
    // ------------------------------------------------------------------
    // A read frame leaves the bank untouched and returns the old contents.
    wire [7:0] rd_val = sel_a ? group_a_reg
                      : (sel_b ? group_b_reg
                      : (sel_cfg ? config_reg : 8'h00));

    // Data bits start at the ninth clock.
    wire       in_data = cnt_reg >= 5'(BYTE_BITS);

    logic       miso_reg;
    logic       miso_oe_reg;

    // The address byte answers zeros; the data byte answers the register.
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            miso_reg    <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else begin
            miso_oe_reg <= frame_on;
            if (frame_beg) begin
                miso_reg <= 1'b0;
            end else if (frame_on && sclk_rise) begin
                miso_reg <= in_data ? rd_val[cnt_reg[2:0]] : 1'b0;
            end
        end
    end

    // The link sees only registered bits.
    assign link.miso    = miso_reg;
    assign link.miso_oe = miso_oe_reg;

    // ------------------------------------------------------------------
    // Switch drive with cross-current blanking
    // ------------------------------------------------------------------
    // Group B sits above group A, one bit pair per bridge.
    wire [2*BRIDGES-1:0] enables = {group_b_reg, group_a_reg};
    logic [BRIDGES-1:0]  high_reg;
    logic [BRIDGES-1:0]  low_reg;

    genvar b;

    generate
        for (b = 0; b < BRIDGES; b++) begin : g_bridge
            wire lo_en = enables[2*b];
            wire hi_en = enables[2*b+1];

            // A bridge with both enables set is held fully off.
            always_ff @(posedge i_core_clk) begin
                if (!i_nrst) begin
                    high_reg[b] <= 1'b0;
                    low_reg[b]  <= 1'b0;
                end else begin
                    high_reg[b] <= hi_en & ~lo_en;
                    low_reg[b]  <= lo_en & ~hi_en;
                end
            end
        end
    endgenerate

    // Every output comes straight from a flip-flop.
    assign o_high_on = high_reg;
    assign o_low_on  = low_reg;
    assign o_group_a = group_a_reg;
    assign o_group_b = group_b_reg;

endmodule : hbe_device

// ===== logic/hbe_host.sv
// Purpose: Serial master that sends one 16-bit frame per software command.
// Assumes: Software uses the plain register port; one frame at a time.
// Notes:   Serial clock is divided from the core clock, idle low.
`timescale 1ns/10ps
module hbe_host
    import hbe_pkg::*;
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    // Register port
    input  wire logic [2:0] i_bus_addr,
    input  wire logic [7:0] i_bus_wdata,
    input  wire logic       i_bus_wr,
    input  wire logic       i_bus_rd,
    output logic      [7:0] o_bus_rdata,
    // Serial link
    hbe_spi_if.host         link
);

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    logic [6:0] tx_addr_reg;
    logic [7:0] tx_data_reg;
    logic [7:0] rx_data_reg;
    logic [7:0] rdata_reg;
    hbe_state_t state_reg;
    hbe_state_t state_next;

    wire busy     = state_reg != HBE_IDLE;
    wire wr_addr  = i_bus_wr & (i_bus_addr == HOFS_TX_ADDR);
    wire wr_data  = i_bus_wr & (i_bus_addr == HOFS_TX_DATA);
    wire wr_ctrl  = i_bus_wr & (i_bus_addr == HOFS_CTRL);
    // A start while a frame runs is ignored.
    wire start    = wr_ctrl & i_bus_wdata[CTRL_START] & ~busy;
    wire [7:0] rd_mux = (i_bus_addr == HOFS_TX_ADDR) ? {1'b0, tx_addr_reg}
                      : (i_bus_addr == HOFS_TX_DATA) ? tx_data_reg
                      : (i_bus_addr == HOFS_STATUS)  ? {7'h00, busy}
                      : (i_bus_addr == HOFS_RX_DATA) ? rx_data_reg : 8'h00;

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            tx_addr_reg <= RST_HOST[6:0];
            tx_data_reg <= RST_HOST;
            rdata_reg   <= RST_HOST;
        end else begin
            if (wr_addr && !busy) begin
                tx_addr_reg <= i_bus_wdata[6:0];
            end
            if (wr_data && !busy) begin
                tx_data_reg <= i_bus_wdata;
            end
            rdata_reg <= i_bus_rd ? rd_mux : 8'h00;
        end
    end

    assign o_bus_rdata = rdata_reg;

    // ------------------------------------------------------------------
    // Half-period divider
    // ------------------------------------------------------------------
    logic [7:0] div_reg;
    wire        tick = busy & (div_reg == 8'(SCLK_HALF_CYC - 1));

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || !busy || tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    logic                  miso_s;
    logic [FRAME_BITS-1:0] tx_reg;
    logic [FRAME_BITS-1:0] rx_reg;
    logic [4:0]            bit_reg;
    logic                  sclk_reg;
    logic                  csn_reg;
    logic                  mosi_reg;

    hbe_sync #(.W(1)) u_sync (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_async    (link.miso_wire),
        .o_sync     (miso_s)
    );

    wire last_fall = tick & sclk_reg & (bit_reg == 5'(FRAME_BITS - 1));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HBE_IDLE:  if (start) state_next = HBE_LEAD;
            HBE_LEAD:  if (tick) state_next = HBE_XFER;
            HBE_XFER:  if (last_fall) state_next = HBE_TRAIL;
            HBE_TRAIL: if (tick) state_next = HBE_GAP;
            HBE_GAP:   if (tick) state_next = HBE_IDLE;
            default:   state_next = HBE_IDLE;
        endcase
    end

    // Data changes on the rising edge and is sampled on the falling edge.
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            state_reg   <= HBE_IDLE;
            sclk_reg    <= 1'b0;
            csn_reg     <= 1'b1;
            mosi_reg    <= 1'b0;
            bit_reg     <= 5'h00;
            tx_reg      <= 16'h0000;
            rx_reg      <= 16'h0000;
            rx_data_reg <= RST_HOST;
        end else begin
            state_reg <= state_next;
            if (start) begin
                // Bit seven of the address byte selects read or write.
                tx_reg  <= {tx_data_reg, i_bus_wdata[CTRL_WRITE], tx_addr_reg};
                csn_reg <= 1'b0;
                bit_reg <= 5'h00;
            end else if (state_reg == HBE_XFER && tick) begin
                sclk_reg <= ~sclk_reg;
                if (!sclk_reg) begin
                    mosi_reg <= tx_reg[0];
                    tx_reg   <= {1'b0, tx_reg[FRAME_BITS-1:1]};
                end else begin
                    rx_reg  <= {miso_s, rx_reg[FRAME_BITS-1:1]};
                    bit_reg <= bit_reg + 5'h01;
                end
            end else if (state_reg == HBE_TRAIL && tick) begin
                csn_reg     <= 1'b1;
                mosi_reg    <= 1'b0;
                rx_data_reg <= rx_reg[FRAME_BITS-1:BYTE_BITS];
            end
        end
    end

    assign link.sclk = sclk_reg;
    assign link.csn  = csn_reg;
    assign link.mosi = mosi_reg;

endmodule : hbe_host

// ===== dv/hbe_link_assertions.sv
// Purpose: Checks on the serial link and the switch outputs of the register bank.
// Assumes: One core clock; synchronous active-low reset.
// Notes:   Watches only the link joining the two design ends.
`timescale 1ns/10ps
module hbe_link_assertions
    import hbe_pkg::*;
(
    // Clock and reset
    input wire logic               i_core_clk,
    input wire logic               i_nrst,
    // Serial link
    input wire logic               sclk,
    input wire logic               csn,
    input wire logic               mosi,
    input wire logic               miso_oe,
    // Device outputs
    input wire logic [7:0]         o_group_a,
    input wire logic [7:0]         o_group_b,
    input wire logic [BRIDGES-1:0] o_high_on,
    input wire logic [BRIDGES-1:0] o_low_on
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [4:0]         rise_reg;
    logic [3:0]         quiet_reg;
    logic [BRIDGES-1:0] hi_w;
    logic [BRIDGES-1:0] lo_w;
    wire  [15:0]        regs_w = {o_group_b, o_group_a};

    // A bridge with both bits set must stay off, so each side needs the other bit low.
    for (genvar k = 0; k < BRIDGES; k++) begin : g_br
        assign hi_w[k] = regs_w[2*k+1] & ~regs_w[2*k];
        assign lo_w[k] = regs_w[2*k] & ~regs_w[2*k+1];
    end

    // Counts clock rises in a frame, and cycles since the frame closed.
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || csn) rise_reg <= 5'h00;
        else if ($rose(sclk)) rise_reg <= rise_reg + 5'h01;
        if (!i_nrst || !csn) quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_reset_vals;
        !$past(i_nrst) |-> regs_w == {RST_GROUP, RST_GROUP} && o_high_on == '0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("register bank not at reset value");
    property p_high;
        o_high_on == $past(hi_w);
    endproperty
    a_high: assert property (p_high)
        else $error("high switch drive does not follow register");
    property p_low;
        o_low_on == $past(lo_w);
    endproperty
    a_low: assert property (p_low)
        else $error("low switch drive does not follow register");
    property p_cross;
        (o_high_on & o_low_on) == '0;
    endproperty
    a_cross: assert property (p_cross)
        else $error("both switches of a bridge on");
    property p_commit;
        $changed(regs_w) |-> csn && quiet_reg < 4'h8;
    endproperty
    a_commit: assert property (p_commit)
        else $error("register changed outside a frame end");
    property p_count;
        $rose(csn) |-> rise_reg == 5'd16;
    endproperty
    a_count: assert property (p_count)
        else $error("frame not sixteen clocks long");
    property p_half;
        $rose(sclk) |-> sclk[*8] ##1 !sclk;
    endproperty
    a_half: assert property (p_half)
        else $error("serial clock high time wrong");
    property p_idle;
        csn |-> !sclk;
    endproperty
    a_idle: assert property (p_idle)
        else $error("serial clock moves outside a frame");
    property p_mosi;
        sclk && $past(sclk) |-> $stable(mosi);
    endproperty
    a_mosi: assert property (p_mosi)
        else $error("data line moved while clock high");
    property p_oe;
        $rose(csn) |-> ##[1:6] !miso_oe;
    endproperty
    a_oe: assert property (p_oe)
        else $error("return line still driven after frame");
endmodule : hbe_link_assertions

// ===== dv/test_half_bridge_enable_regs.sv
// Purpose: Self-checking bench for the host and register bank joined by the link.
// Assumes: 40 MHz core clock; a second bank is driven bit by bit from here.
// Notes:   Expected read data wait in a queue until the monitor sees them.
`timescale 1ns/10ps
module test_half_bridge_enable_regs;
    import hbe_pkg::*;
    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic               i_core_clk;
    logic               i_nrst;
    logic [2:0]         bus_addr;
    logic [7:0]         bus_wdata;
    logic               bus_wr;
    logic               bus_rd;
    logic               rd_note;
    logic [7:0]         bus_rdata;
    logic [7:0]         grp_a;
    logic [7:0]         grp_b;
    logic [7:0]         grp2_a;
    logic [BRIDGES-1:0] hi;
    logic [BRIDGES-1:0] lo;
    logic [7:0]         exp_a;
    logic [7:0]         exp_b;
    logic [7:0]         rnd;
    logic [7:0]         wv;
    logic [7:0]         pick [4] = '{8'h55, 8'haa, 8'hff, 8'h3c};
    logic [7:0]         notes [$];
    int                 mismatches;
    int                 checked;
    int                 cycles;

    hbe_spi_if link ();
    hbe_spi_if link2 ();
    hbe_host hbe_host_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_bus_addr(bus_addr),
        .i_bus_wdata(bus_wdata), .i_bus_wr(bus_wr), .i_bus_rd(bus_rd),
        .o_bus_rdata(bus_rdata), .link(link));
    hbe_device hbe_device_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .link(link),
        .o_group_a(grp_a), .o_group_b(grp_b), .o_high_on(hi), .o_low_on(lo));
    // This bank sees frames from the bench, so broken frames can be sent on purpose.
    hbe_device hbe_device_probe_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .link(link2),
        .o_group_a(grp2_a), .o_group_b(), .o_high_on(), .o_low_on());
    hbe_link_assertions hbe_link_assertions_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .sclk(link.sclk), .csn(link.csn), .mosi(link.mosi), .miso_oe(link.miso_oe),
        .o_group_a(grp_a), .o_group_b(grp_b), .o_high_on(hi), .o_low_on(lo));

    // Free-running core clock.
    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Each strobe is dropped at the next edge, so calls never collide in one step.
    task automatic write_port(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge i_core_clk);
        bus_wr    <= 1'b0;
    endtask : write_port

    task automatic read_port(input logic [2:0] a);
        @(posedge i_core_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge i_core_clk);
        bus_rd   <= 1'b0;
    endtask : read_port

    // One full frame through the host; the returned byte is the old register value.
    task automatic frame(input logic op, input logic [4:0] pat, input logic [7:0] d,
                         input logic [7:0] old);
        write_port(HOFS_TX_ADDR, {1'b0, pat, 2'b01});
        write_port(HOFS_TX_DATA, d);
        write_port(HOFS_CTRL, {6'h00, op, 1'b1});
        for (int n = 0; n < 2000; n++) begin
            read_port(HOFS_STATUS);
            @(negedge i_core_clk);
            if (bus_rdata[STAT_BUSY] === 1'b0) break;
        end
        repeat (6) @(posedge i_core_clk);
        notes.push_back(old);
        read_port(HOFS_RX_DATA);
    endtask : frame

    // Frame of n bits to the probe bank; the data line is left inverted afterwards.
    task automatic raw(input logic [15:0] w, input int n);
        @(posedge i_core_clk);
        link2.csn <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        for (int b = 0; b < n; b++) begin
            link2.sclk <= 1'b1;
            link2.mosi <= w[b];
            repeat (8) @(posedge i_core_clk);
            link2.sclk <= 1'b0;
            repeat (8) @(posedge i_core_clk);
        end
        link2.csn  <= 1'b1;
        link2.mosi <= ~w[n-1];
        repeat (16) @(posedge i_core_clk);
    endtask : raw

    task automatic check_outs();
        logic [15:0]        r;
        logic [BRIDGES-1:0] eh;
        logic [BRIDGES-1:0] el;
        r = {exp_b, exp_a};
        for (int k = 0; k < BRIDGES; k++) begin
            eh[k] = r[2*k+1] & ~r[2*k];
            el[k] = r[2*k] & ~r[2*k+1];
        end
        chk("group_a", grp_a, exp_a);
        chk("group_b", grp_b, exp_b);
        chk("high_on", hi, eh);
        chk("low_on", lo, el);
    endtask : check_outs

    // ------------------------------------------------------------------
    // Monitor and timeout
    // ------------------------------------------------------------------
    // Read data stand only in the cycle after the strobe, so they are taken right there.
    always @(posedge i_core_clk) begin
        if (rd_note) chk("read_data", bus_rdata, notes.size() ? notes.pop_front() : 8'hxx);
        rd_note <= bus_rd && (bus_addr != HOFS_STATUS);
        cycles++;
        if (cycles > 30000) begin
            mismatches++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        i_nrst     = 1'b0;
        bus_addr   = 3'h0;
        bus_wdata  = 8'h00;
        bus_wr     = 1'b0;
        bus_rd     = 1'b0;
        link2.sclk = 1'b0;
        link2.csn  = 1'b1;
        link2.mosi = 1'b0;
        rnd        = 8'h4b;
        exp_a      = RST_GROUP;
        exp_b      = RST_GROUP;
        repeat (16) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        @(posedge i_core_clk);
        check_outs();
        frame(1'b0, PAT_CONFIG, 8'h00, RST_CONFIG);
        frame(1'b0, PAT_GROUP_A, 8'h00, RST_GROUP);
        frame(1'b0, PAT_GROUP_B, 8'h00, RST_GROUP);
        // Even passes hit group A and odd passes group B, then read back unchanged.
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wv  = (i < 4) ? pick[i] : rnd;
            if (i % 2 == 1) begin
                frame(1'b1, PAT_GROUP_B, wv, exp_b);
                exp_b = wv;
            end else begin
                frame(1'b1, PAT_GROUP_A, wv, exp_a);
                exp_a = wv;
            end
            check_outs();
            frame(1'b0, (i % 2 == 1) ? PAT_GROUP_B : PAT_GROUP_A, ~wv, wv);
            check_outs();
        end
        frame(1'b1, PAT_CONFIG, 8'hfe, RST_CONFIG);
        frame(1'b0, PAT_CONFIG, 8'h00, RST_CONFIG);
        frame(1'b1, 5'h08, 8'hff, 8'h00);
        check_outs();
        notes.push_back(8'h00);
        read_port(3'h5);
        raw(16'hff81, 15);
        chk("probe_a", grp2_a, RST_GROUP);
        raw(16'h5a81, 16);
        chk("probe_a", grp2_a, 8'h5a);
        raw(16'hc301, 16);
        chk("probe_a", grp2_a, 8'h5a);
        repeat (4) @(posedge i_core_clk);
        results();
    end
endmodule : test_half_bridge_enable_regs
